// *** hdl/sra_pkg.sv ***
// Function
// - Decode reads in the 2004.0000-2007.FFFF window
// - Small parts appear twice, top bit undecoded
// - Reads return full words, one lane per part
// - Address bits 9:2 latched at cycle start
// - Latch full address, decode select, drive upper lines
// - ROM word to buffered bus and CPU
// - Low byte from CPU, high byte from decode
// - Top bit follows address 17 or held high
// - Interrupt acknowledge selects ROM at vector entry
// - Vector entry returned as service routine address
// - Only this logic drives chip select, output enable
// - Each part carries its index and checksum
// - Part index zero low lane, three high
// - Check bytes 55h, AAh, 33h consecutive
package sra_pkg;

  // ==========================================================
  // Address window and ROM address layout
  localparam logic [13:0] ROM_WINDOW_TAG  = 14'h0801;
  localparam int          WINDOW_TAG_LSB  = 18;
  localparam int          LOW_LATCH_LSB   = 2;
  localparam int          HIGH_LINES_LSB  = 10;
  localparam int          TOP_BIT_POS     = 17;
  localparam logic [7:0]  VEC_TABLE_WORD  = 8'h08;
  localparam logic [6:0]  VEC_HIGH_LINES  = 7'h00;

  // ==========================================================
  // Per-part layout
  localparam logic [15:0] INDEX_WORD      = 16'h0003;
  localparam logic [15:0] CHECK0_WORD     = 16'h0004;
  localparam logic [15:0] CHECK1_WORD     = 16'h0005;
  localparam logic [15:0] CHECK2_WORD     = 16'h0006;
  localparam logic [15:0] LAST_WORD       = 16'hFFFF;
  localparam logic [7:0]  CHECK0_BYTE     = 8'h55;
  localparam logic [7:0]  CHECK1_BYTE     = 8'hAA;
  localparam logic [7:0]  CHECK2_BYTE     = 8'h33;

  // ==========================================================
  // Timing
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          ROM_ACCESS_NS   = 200;
  localparam int          ACCESS_CYC      =
    (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  ACCESS_CNT      = 4'(ACCESS_CYC - 1);

  // ==========================================================
  // Reset values
  localparam logic [31:0] WORD_RESET      = 32'h0000_0000;

  typedef enum logic [2:0] {
    SRA_IDLE   = 3'b001,
    SRA_ACCESS = 3'b010,
    SRA_DONE   = 3'b100
  } sra_state_t;

endpackage : sra_pkg

// *** hdl/sra_rom_path.sv ***
`timescale 1ns/1ps
module sra_rom_path
  import sra_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        cycStart,
  input  wire logic [31:0] cpuAddr,
  input  wire logic        intAck,
  input  wire logic [2:0]  vecIndex,
  input  wire logic        romSizeJumper,
  input  wire logic [31:0] memoryDataBus,
  output logic      [7:0]  lowAddrLatch,
  output logic      [6:0]  memoryAddressLines,
  output logic             topRomAddressBit,
  output logic             romCsN,
  output logic             romOeN,
  output logic      [31:0] bufferedSystemDataBus,
  output logic      [31:0] cpuMuxedAddrDataBus,
  output logic             cpuBusOe,
  output logic             romReadDone,
  output logic      [3:0]  partIndexOk,
  output logic      [3:0]  checkBytesOk,
  output logic      [31:0] romChecksum
);

  // ==========================================================
  // Helpers
  function automatic logic romHit(input logic [31:0] a);
    romHit = (a[31:WINDOW_TAG_LSB] == ROM_WINDOW_TAG);
  endfunction : romHit

  function automatic logic [7:0] laneByte(input logic [31:0] w,
                                          input int         lane);
    laneByte = w[lane*8 +: 8];
  endfunction : laneByte

  sra_state_t state_reg;
  logic [3:0]  waitCnt_reg;
  logic [31:0] fullAddr_reg;
  logic        isVector_reg;
  logic        accept;
  logic [15:0] romWord;

  assign accept  = (state_reg == SRA_IDLE) && cycStart
                   && (intAck || romHit(cpuAddr));
  assign romWord = {topRomAddressBit, memoryAddressLines, lowAddrLatch};

  // ==========================================================
  // Cycle sequencer
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= SRA_IDLE;
      waitCnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        SRA_IDLE: begin
          if (accept) begin
            state_reg   <= SRA_ACCESS;
            waitCnt_reg <= ACCESS_CNT;
          end
        end
        SRA_ACCESS: begin
          if (waitCnt_reg == 4'h0) begin
            state_reg <= SRA_DONE;
          end else begin
            waitCnt_reg <= waitCnt_reg - 4'h1;
          end
        end
        SRA_DONE: begin
          state_reg <= SRA_IDLE;
        end
        default: begin
          state_reg <= SRA_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Address capture and ROM address lines
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fullAddr_reg       <= WORD_RESET;
      isVector_reg       <= 1'b0;
      lowAddrLatch       <= 8'h00;
      memoryAddressLines <= 7'h00;
      topRomAddressBit   <= 1'b1;
    end else if (accept) begin
      fullAddr_reg <= cpuAddr;
      isVector_reg <= intAck;
      if (intAck) begin
        lowAddrLatch       <= VEC_TABLE_WORD + {5'h00, vecIndex};
        memoryAddressLines <= VEC_HIGH_LINES;
        topRomAddressBit   <= ~romSizeJumper;
      end else begin
        lowAddrLatch       <= cpuAddr[LOW_LATCH_LSB +: 8];
        memoryAddressLines <= cpuAddr[HIGH_LINES_LSB +: 7];
        // Small parts ignore the top bit, so their image repeats
        topRomAddressBit   <= romSizeJumper ?
                              cpuAddr[TOP_BIT_POS] : 1'b1;
      end
    end
  end

  // ==========================================================
  // Strobes, owned solely by this logic
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      romCsN <= 1'b1;
      romOeN <= 1'b1;
    end else begin
      romCsN <= ~(accept || (state_reg == SRA_ACCESS
                             && waitCnt_reg != 4'h0));
      romOeN <= ~(accept || (state_reg == SRA_ACCESS
                             && waitCnt_reg != 4'h0));
    end
  end

  // ==========================================================
  // Data return path
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bufferedSystemDataBus <= WORD_RESET;
      cpuMuxedAddrDataBus   <= WORD_RESET;
      cpuBusOe              <= 1'b0;
      romReadDone           <= 1'b0;
    end else begin
      romReadDone <= 1'b0;
      cpuBusOe    <= 1'b0;
      if (state_reg == SRA_ACCESS && waitCnt_reg == 4'h0) begin
        bufferedSystemDataBus <= memoryDataBus;
        romReadDone           <= 1'b1;
      end
      if (state_reg == SRA_DONE) begin
        cpuMuxedAddrDataBus <= bufferedSystemDataBus;
        cpuBusOe            <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Per-part identification and check bytes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      partIndexOk  <= 4'h0;
      checkBytesOk <= 4'h0;
      romChecksum  <= WORD_RESET;
    end else if (state_reg == SRA_ACCESS && waitCnt_reg == 4'h0
                 && !isVector_reg) begin
      for (int i = 0; i < 4; i++) begin
        if (romWord == INDEX_WORD) begin
          partIndexOk[i] <= (laneByte(memoryDataBus, i)
                             == 8'(i));
        end
        if (romWord == CHECK0_WORD) begin
          checkBytesOk[i] <= (laneByte(memoryDataBus, i)
                              == CHECK0_BYTE);
        end
        if (romWord == CHECK1_WORD && laneByte(memoryDataBus, i)
            != CHECK1_BYTE) begin
          checkBytesOk[i] <= 1'b0;
        end
        if (romWord == CHECK2_WORD && laneByte(memoryDataBus, i)
            != CHECK2_BYTE) begin
          checkBytesOk[i] <= 1'b0;
        end
      end
      if (romWord == LAST_WORD) begin
        romChecksum <= memoryDataBus;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_window;
    cycStart && !intAck && !romHit(cpuAddr) && state_reg == SRA_IDLE
      |=> romCsN;
  endproperty
  a_window: assert property (p_window)
    else $error("ROM selected outside its window");

  property p_top_small;
    accept && !intAck && !romSizeJumper |=> topRomAddressBit;
  endproperty
  a_top_small: assert property (p_top_small)
    else $error("Top ROM bit not held high for small parts");

  property p_top_large;
    accept && !intAck && romSizeJumper
      |=> topRomAddressBit == $past(cpuAddr[TOP_BIT_POS]);
  endproperty
  a_top_large: assert property (p_top_large)
    else $error("Top ROM bit does not follow address bit 17");

  property p_low_latch;
    accept && !intAck
      |=> lowAddrLatch == $past(cpuAddr[9:2])
          && memoryAddressLines == $past(cpuAddr[16:10]);
  endproperty
  a_low_latch: assert property (p_low_latch)
    else $error("ROM address not taken from the CPU address");

  property p_vector;
    accept && intAck
      |=> lowAddrLatch == VEC_TABLE_WORD + {5'h00, $past(vecIndex)}
          && memoryAddressLines == VEC_HIGH_LINES && !romCsN;
  endproperty
  a_vector: assert property (p_vector)
    else $error("Vector cycle does not address vector entry");

  property p_strobe_len;
    accept |=> !romCsN [*5] ##1 romCsN;
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("Chip select length wrong");

  property p_strobes_same;
    romCsN == romOeN;
  endproperty
  a_strobes_same: assert property (p_strobes_same)
    else $error("Chip select and output enable disagree");

  property p_data;
    romReadDone |-> bufferedSystemDataBus == $past(memoryDataBus)
                    ##1 cpuBusOe
                    && cpuMuxedAddrDataBus == $past(bufferedSystemDataBus);
  endproperty
  a_data: assert property (p_data)
    else $error("ROM word not passed to the CPU");

  property p_done_time;
    accept |-> ##6 romReadDone ##1 cpuBusOe ##1 !cpuBusOe;
  endproperty
  a_done_time: assert property (p_done_time)
    else $error("ROM word returned at the wrong cycle");

endmodule : sra_rom_path

// *** tb/sra_rom_model.sv ***
`timescale 1ns/1ps
module sra_rom_model
  import sra_pkg::*;
(
  input  wire logic [7:0]  lowAddrLatch,
  input  wire logic [6:0]  memoryAddressLines,
  input  wire logic        topRomAddressBit,
  input  wire logic        romCsN,
  input  wire logic        romOeN,
  input  wire logic        romCorrupt,
  output logic      [31:0] memoryDataBus
);
  logic [15:0] romWord;
  logic [31:0] content;

  assign romWord = {topRomAddressBit, memoryAddressLines, lowAddrLatch};

  // ==========================================================
  // Four byte parts, lane i is part i
  always_comb begin
    case (romWord)
      INDEX_WORD:  content = 32'h0302_0100;
      CHECK0_WORD: content = {4{CHECK0_BYTE}};
      CHECK1_WORD: content = {4{CHECK1_BYTE}};
      CHECK2_WORD: content = {4{CHECK2_BYTE}};
      LAST_WORD:   content = 32'hC0C1_C2C3;
      default:     content = {~romWord, romWord};
    endcase
  end

  // Released bus shows the inverse, never a stale word
  // Corruption flips lane 0 to stand for a bad part
  assign memoryDataBus = (!romCsN && !romOeN)
                         ? content ^ {24'h00_0000, {8{romCorrupt}}}
                         : ~content;
endmodule : sra_rom_model

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench
  import sra_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cycStart = 1'b0;
  logic [31:0] cpuAddr = 32'h0;
  logic        intAck = 1'b0;
  logic [2:0]  vecIndex = 3'h0;
  logic        romSizeJumper = 1'b1;
  logic        romCorrupt = 1'b0;
  logic [31:0] memoryDataBus;
  logic [7:0]  lowAddrLatch;
  logic [6:0]  memoryAddressLines;
  logic        topRomAddressBit;
  logic        romCsN;
  logic        romOeN;
  logic [31:0] bufferedSystemDataBus;
  logic [31:0] cpuMuxedAddrDataBus;
  logic        cpuBusOe;
  logic        romReadDone;
  logic [3:0]  partIndexOk;
  logic [3:0]  checkBytesOk;
  logic [31:0] romChecksum;
  int          n_mismatch = 0;
  int          n_tests = 0;

  always #20 ref_clk = ~ref_clk;

  sra_rom_path dut (.ref_clk(ref_clk), .rstn(rstn), .cycStart(cycStart),
    .cpuAddr(cpuAddr), .intAck(intAck), .vecIndex(vecIndex),
    .romSizeJumper(romSizeJumper), .memoryDataBus(memoryDataBus),
    .lowAddrLatch(lowAddrLatch), .memoryAddressLines(memoryAddressLines),
    .topRomAddressBit(topRomAddressBit), .romCsN(romCsN), .romOeN(romOeN),
    .bufferedSystemDataBus(bufferedSystemDataBus),
    .cpuMuxedAddrDataBus(cpuMuxedAddrDataBus), .cpuBusOe(cpuBusOe),
    .romReadDone(romReadDone), .partIndexOk(partIndexOk),
    .checkBytesOk(checkBytesOk), .romChecksum(romChecksum));

  sra_rom_model rom (.lowAddrLatch(lowAddrLatch), .romCorrupt(romCorrupt),
    .memoryAddressLines(memoryAddressLines),
    .topRomAddressBit(topRomAddressBit), .romCsN(romCsN), .romOeN(romOeN),
    .memoryDataBus(memoryDataBus));

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] expWord(input logic [15:0] w);
    case (w)
      INDEX_WORD:  return 32'h0302_0100;
      CHECK0_WORD: return 32'h5555_5555;
      CHECK1_WORD: return 32'hAAAA_AAAA;
      CHECK2_WORD: return 32'h3333_3333;
      LAST_WORD:   return 32'hC0C1_C2C3;
      default:     return {~w, w};
    endcase
  endfunction : expWord

  // Entered just after an edge; poke retries cycStart while busy
  task automatic access(input logic [31:0] a, input logic ack,
                        input logic [2:0] v, input bit poke);
    logic [15:0] w;
    logic [31:0] expData;
    int          n;
    w = ack ? {~romSizeJumper, 7'h00, VEC_TABLE_WORD + 8'(v)}
            : {romSizeJumper ? a[17] : 1'b1, a[16:2]};
    expData = expWord(w) ^ {24'h00_0000, {8{romCorrupt}}};
    cpuAddr = a;
    intAck = ack;
    vecIndex = v;
    cycStart = 1'b1;
    @(posedge ref_clk);
    #1 cycStart = poke;
    cpuAddr = a + 32'h100;
    @(posedge ref_clk);
    #1 cycStart = 1'b0;
    check("strobes", {30'h0, romCsN, romOeN}, 32'h0);
    n = 1;
    while (romReadDone !== 1'b1 && n < 12) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check("done", n, ACCESS_CYC);
    check("release", {30'h0, romCsN, romOeN}, 32'h3);
    check("lowAddr", 32'(lowAddrLatch), 32'(w[7:0]));
    check("hiAddr", 32'(memoryAddressLines), 32'(w[14:8]));
    check("topBit", 32'(topRomAddressBit), 32'(w[15]));
    check("bufData", bufferedSystemDataBus, expData);
    @(posedge ref_clk);
    #1 check("cpuOe", 32'(cpuBusOe), 32'h1);
    check("cpuData", cpuMuxedAddrDataBus, expData);
  endtask : access

  // ==========================================================
  // Scenarios
  task automatic t_part_data();
    romSizeJumper = 1'b1;
    for (int i = 3; i < 7; i++) begin
      access(32'h2004_0000 + 32'(4 * i), 1'b0, 3'h0, i == 3);
    end
    check("index", 32'(partIndexOk), 32'hF);
    check("checks", 32'(checkBytesOk), 32'hF);
    romCorrupt = 1'b1;
    access(32'h2004_000C, 1'b0, 3'h0, 1'b0);
    access(32'h2004_0014, 1'b0, 3'h0, 1'b0);
    romCorrupt = 1'b0;
    check("badIndex", 32'(partIndexOk), 32'hE);
    check("badChecks", 32'(checkBytesOk), 32'hE);
    access(32'h2007_FFFC, 1'b0, 3'h0, 1'b0);
    check("chksum", romChecksum, 32'hC0C1_C2C3);
    access(32'h2004_1234, 1'b0, 3'h0, 1'b1);
  endtask : t_part_data

  task automatic t_small_parts();
    romSizeJumper = 1'b0;
    access(32'h2005_FFFC, 1'b0, 3'h0, 1'b0);
    access(32'h2004_1234, 1'b0, 3'h0, 1'b0);
  endtask : t_small_parts

  task automatic t_vectors();
    for (int j = 0; j < 2; j++) begin
      romSizeJumper = j[0];
      for (int v = 0; v < 8; v++) access(32'h0, 1'b1, 3'(v), 1'b0);
    end
  endtask : t_vectors

  task automatic t_outside();
    logic [31:0] bad [2] = '{32'h2008_0000, 32'h2003_FFFC};
    foreach (bad[k]) begin
      cpuAddr = bad[k];
      intAck = 1'b0;
      cycStart = 1'b1;
      repeat (9) begin
        @(posedge ref_clk);
        #1 cycStart = 1'b0;
        check("idle", {30'h0, romCsN, romReadDone}, 32'h2);
      end
    end
  endtask : t_outside

  // Reset in the middle of an access, then a clean access
  task automatic t_reset();
    romSizeJumper = 1'b1;
    cpuAddr = 32'h2004_1000;
    intAck = 1'b0;
    cycStart = 1'b1;
    @(posedge ref_clk);
    #1 cycStart = 1'b0;
    @(posedge ref_clk);
    #1 rstn = 1'b0;
    #1;
    check("midRst", {29'h0, romCsN, romOeN, romReadDone}, 32'h6);
    check("rstFlags", {24'h0, partIndexOk, checkBytesOk}, 32'h0);
    repeat (2) @(posedge ref_clk);
    #1 rstn = 1'b1;
    repeat (2) begin
      @(posedge ref_clk);
      #1 check("afterRst", {30'h0, romCsN, romReadDone}, 32'h2);
    end
    access(32'h2004_1000, 1'b0, 3'h0, 1'b0);
  endtask : t_reset

  task automatic end_sim();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    check("rst", {29'h0, romCsN, romOeN, topRomAddressBit}, 32'h7);
    check("rstDone", {30'h0, romReadDone, cpuBusOe}, 32'h0);
    rstn = 1'b1;
    t_part_data();
    t_small_parts();
    t_vectors();
    t_outside();
    t_reset();
    end_sim();
  end

  initial begin
    #100000 n_mismatch++;
    end_sim();
  end
endmodule : testbench
